// [rtl/ecs_pkg.sv]
// Constants for the encoder cyclic status word block
package ecs_pkg;
    // APB register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SHIFT = 8'h04;
    localparam logic [7:0] REG_PRESET = 8'h08;
    localparam logic [7:0] REG_ERRCODE = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_POS = 8'h14;
    localparam logic [7:0] REG_OFFSET = 8'h18;

    // Control and shift register fields
    localparam int CTRL_COMPAT = 0;
    localparam int CTRL_CTRLREQ = 1;
    localparam int CTRL_INITDONE = 2;
    localparam int SHIFT1_LSB = 0;
    localparam int SHIFT2_LSB = 8;
    localparam int SHIFT_W = 5;

    // Sensor control word bits
    localparam int SCW_MODE = 11;
    localparam int SCW_PRESET = 12;
    localparam int SCW_ABSREQ = 13;
    localparam int SCW_PARK = 14;
    localparam int SCW_ACK = 15;
    // Encoder control word bits
    localparam int ECW_CTRLPLC = 10;

    // Sensor status word bits
    localparam int SSW_ACKREQ = 11;
    localparam int SSW_PRESETDONE = 12;
    localparam int SSW_ABSVAL = 13;
    localparam int SSW_PARKED = 14;
    localparam int SSW_ERROR = 15;
    // Encoder status word bits
    localparam int ESW_FAULT = 3;
    localparam int ESW_WARN = 7;
    localparam int ESW_CTRLREQ = 9;
    localparam logic [15:0] SSW_USED_MASK = 16'hf800;
    localparam logic [15:0] ESW_USED_MASK = 16'hf288;

    // Frame bit slices: encoder control word first, two bytes each
    localparam int RX_ENC_LSB = 16;
    localparam int RX_SNS_LSB = 0;

    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] PRESET_RST = 32'h0000_0000;
    localparam logic [31:0] ERRCODE_RST = 32'h0000_0001;
endpackage : ecs_pkg

// [rtl/ecs_status_words.sv]
// Cyclic status, position and velocity words of a networked absolute encoder
// Operation
// RQ1: Sensor status uses only bits 11 to 15
// RQ2: Error raises ack-required; controller ack clears it
// RQ3: Sensor error bit holds while error persists
// RQ4: Preset/offset applied gives 0-to-1 on bit 12
// RQ5: Bit 13 marks absolute position in word two
// RQ6: Parked bit while initializing or park requested
// RQ7: Encoder status uses bits 15-12, 9, 7, 3
// RQ8: Fault bit follows any active fault
// RQ9: Warning bit is always zero
// RQ10: Bit 9 requests controller take control
// RQ11: No encoder sign-of-life counter implemented
// RQ12: Nonzero shift factor shifts left, zero fill
// RQ13: First word is right-aligned 32-bit position
// RQ14: Wide word right aligned, upper half zero
// RQ15: Word two: position on request, error code
// RQ16: Controller treats word two invalid when 13,15 clear
// RQ17: Velocity sent right aligned, 16 and 32 bit
// RQ18: Frame in: encoder control then sensor control
// RQ19: Frame out: enc status, sns status, two positions
// RQ20: Controller treats values invalid during fault
// RQ21: Controller holds preset request until bit 12
// RQ22: Mode bit chooses preset or offset add
// RQ23: Controller bit 13 asks position or zero
// RQ24: Control handshake unless compatibility mode
// RQ25: Unused status bits driven to zero
// RQ26: Control edges found against previous frame
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module ecs_status_words
    import ecs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxValid,
    input wire logic [31:0] rxFrame,
    input wire logic sensorErrPin,
    input wire logic [31:0] rawPosition,
    input wire logic [31:0] rawVelocity,
    output logic [15:0] encStatusWord,
    output logic [15:0] sensorStatusWord,
    output logic [31:0] firstPositionWord,
    output logic [31:0] secondPositionWord,
    output logic [63:0] widePositionWord,
    output logic [15:0] velocityShort,
    output logic [31:0] velocityLong,
    output logic [95:0] txFrame
);

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic compat;
        logic ctrlReq;
        logic initDone;
        logic [SHIFT_W-1:0] shift1;
        logic [SHIFT_W-1:0] shift2;
        logic [31:0] presetVal;
        logic [31:0] errCode;
        logic [31:0] offset;
        logic [15:0] encCtrl;
        logic [15:0] snsCtrl;
        logic sync1;
        logic sync2;
        logic sync3;
        logic errStable;
        logic ackReq;
        logic presetDone;
        logic [15:0] snsStat;
        logic [15:0] encStat;
        logic [31:0] pos1;
        logic [31:0] pos2;
        logic [63:0] wide;
        logic [15:0] velS;
        logic [31:0] velL;
        logic [95:0] tx;
    } ecs_state_t;

    ecs_state_t s_q;
    ecs_state_t s_d;

    logic [15:0] rxEnc;
    logic [15:0] rxSns;
    logic accept;
    logic [15:0] rise;
    logic errNew;
    logic errRise;
    logic parked;
    logic [31:0] posAbs;
    logic apbWrite;
    logic apbSetup;
    logic mapped;

    // Frame split: encoder control word occupies the first two bytes
    assign rxEnc = rxFrame[RX_ENC_LSB +: 16]; // [RQ18]
    assign rxSns = rxFrame[RX_SNS_LSB +: 16]; // [RQ18]
    // Data taken only after the control handshake, or always in compat mode
    assign accept = rxValid && (s_q.compat || rxEnc[ECW_CTRLPLC]); // [RQ24]
    // Edges seen against the previously accepted frame
    assign rise = rxSns & ~s_q.snsCtrl; // [RQ26]
    // Filtered error: only a stable pair of late stages counts
    assign errNew = (s_q.sync2 == s_q.sync3) ? s_q.sync3 : s_q.errStable;
    assign errRise = errNew && !s_q.errStable;
    // Parked before init completes or on controller request
    assign parked = !s_q.initDone || s_q.snsCtrl[SCW_PARK]; // [RQ6]
    // Sum wraps on purpose: position is modulo the 32-bit word
    assign posAbs = 32'(rawPosition + s_q.offset);
    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pwrite && s_q.pready;
    assign mapped = (paddr == REG_CTRL) || (paddr == REG_SHIFT) || (paddr == REG_PRESET)
        || (paddr == REG_ERRCODE) || (paddr == REG_STATUS) || (paddr == REG_POS)
        || (paddr == REG_OFFSET);

    // Next-state logic for the whole block
    always_comb begin
        s_d = s_q;
        // Three-stage sampler on the asynchronous error pin
        s_d.sync1 = sensorErrPin;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        s_d.errStable = errNew;

        // APB: answer with zero wait states, read data latched in setup
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        if (apbSetup) begin
            s_d.pready = 1'b1;
            s_d.pslverr = !mapped;
            unique case (paddr)
                REG_CTRL: s_d.prdata = {29'h0, s_q.initDone, s_q.ctrlReq, s_q.compat};
                REG_SHIFT: s_d.prdata = {19'h0, s_q.shift2, 3'h0, s_q.shift1};
                REG_PRESET: s_d.prdata = s_q.presetVal;
                REG_ERRCODE: s_d.prdata = s_q.errCode;
                REG_STATUS: s_d.prdata = {s_q.encStat, s_q.snsStat};
                REG_POS: s_d.prdata = s_q.pos1;
                REG_OFFSET: s_d.prdata = s_q.offset;
                default: s_d.prdata = 32'h0000_0000;
            endcase
        end
        if (apbWrite) begin
            unique case (paddr)
                REG_CTRL: begin
                    s_d.compat = pwdata[CTRL_COMPAT];
                    s_d.ctrlReq = pwdata[CTRL_CTRLREQ];
                    s_d.initDone = pwdata[CTRL_INITDONE];
                end
                REG_SHIFT: begin
                    s_d.shift1 = pwdata[SHIFT1_LSB +: SHIFT_W];
                    s_d.shift2 = pwdata[SHIFT2_LSB +: SHIFT_W];
                end
                REG_PRESET: s_d.presetVal = pwdata;
                REG_ERRCODE: s_d.errCode = pwdata;
                default: ;
            endcase
        end

        // Accepted frame updates the stored control words
        if (accept) begin
            s_d.encCtrl = rxEnc;
            s_d.snsCtrl = rxSns;
            // Preset sets the position to the stored value; offset adds it
            if (rise[SCW_PRESET]) begin
                if (rxSns[SCW_MODE]) begin
                    s_d.offset = 32'(s_q.offset + s_q.presetVal); // [RQ22]
                end else begin
                    s_d.offset = 32'(s_q.presetVal - rawPosition); // [RQ22]
                end
                s_d.presetDone = 1'b1; // [RQ4]
            end else if (!rxSns[SCW_PRESET]) begin
                // Dropped request rearms so the next completion is a fresh edge
                s_d.presetDone = 1'b0; // [RQ4]
            end
            if (rxSns[SCW_ACK]) begin
                s_d.ackReq = 1'b0; // [RQ2]
            end
        end
        // Parking clears pending error messages
        if (parked) begin
            s_d.ackReq = 1'b0;
        end
        // A new error wins over an acknowledge in the same cycle
        if (errRise) begin
            s_d.ackReq = 1'b1; // [RQ2]
        end

        // Sensor status word: only the top five bits carry meaning
        s_d.snsStat = 16'h0000; // [RQ1] [RQ25]
        s_d.snsStat[SSW_ACKREQ] = s_q.ackReq; // [RQ2]
        s_d.snsStat[SSW_PRESETDONE] = s_q.presetDone; // [RQ4]
        s_d.snsStat[SSW_ABSVAL] = s_q.snsCtrl[SCW_ABSREQ] && !s_q.errStable; // [RQ5]
        s_d.snsStat[SSW_PARKED] = parked; // [RQ6]
        s_d.snsStat[SSW_ERROR] = s_q.errStable; // [RQ3]

        // Encoder status word; warning and sign-of-life stay zero
        s_d.encStat = 16'h0000; // [RQ7] [RQ9] [RQ11] [RQ25]
        s_d.encStat[ESW_FAULT] = s_q.errStable; // [RQ8]
        s_d.encStat[ESW_CTRLREQ] = s_q.ctrlReq; // [RQ10]

        // Position words; no interpolation, so shifting only pads zeros
        s_d.pos1 = posAbs << s_q.shift1; // [RQ12] [RQ13]
        if (s_q.errStable) begin
            s_d.pos2 = s_q.errCode; // [RQ3] [RQ15]
        end else if (s_q.snsCtrl[SCW_ABSREQ]) begin
            s_d.pos2 = posAbs << s_q.shift2; // [RQ12] [RQ15]
        end else begin
            s_d.pos2 = 32'h0000_0000; // [RQ5]
        end
        s_d.wide = {32'h0000_0000, posAbs}; // [RQ14]
        s_d.velS = rawVelocity[15:0]; // [RQ17]
        s_d.velL = rawVelocity; // [RQ17]
        // Outgoing frame mirrors the registered words, most significant first
        s_d.tx = {s_q.encStat, s_q.snsStat, s_q.pos1, s_q.pos2}; // [RQ19]
    end

    // State register; reset ignores the clock enable
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.compat <= CTRL_RST[CTRL_COMPAT];
            s_q.ctrlReq <= CTRL_RST[CTRL_CTRLREQ];
            s_q.initDone <= CTRL_RST[CTRL_INITDONE];
            s_q.presetVal <= PRESET_RST;
            s_q.errCode <= ERRCODE_RST;
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state flops
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign encStatusWord = s_q.encStat;
    assign sensorStatusWord = s_q.snsStat;
    assign firstPositionWord = s_q.pos1;
    assign secondPositionWord = s_q.pos2;
    assign widePositionWord = s_q.wide;
    assign velocityShort = s_q.velS;
    assign velocityLong = s_q.velL;
    assign txFrame = s_q.tx;

    // Checks on the behaviour above
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    // Named steps of the error and preset handshakes
    sequence errArrives;
        clkEn && errRise;
    endsequence

    sequence ackSeen;
        clkEn && accept && rxSns[SCW_ACK] && !errRise;
    endsequence

    sequence presetEdge;
        clkEn && accept && rise[SCW_PRESET];
    endsequence

    sequence presetDropped;
        clkEn && accept && !rxSns[SCW_PRESET];
    endsequence

    // Sensor status low bits carry nothing
    a_sns_unused: assert property (sensorStatusWord[10:0] == 11'h000) // [RQ1]
        else $error("sensor status low bits not zero");

    // Encoder status only on its used positions
    a_enc_unused: assert property ( // [RQ7]
        (encStatusWord & ~ESW_USED_MASK) == 16'h0000)
        else $error("encoder status unused bits set");

    // No warnings are ever reported
    a_warn_zero: assert property (!encStatusWord[ESW_WARN]) // [RQ9]
        else $error("warning bit set");

    // Sign-of-life field left empty
    a_life_zero: assert property (encStatusWord[15:12] == 4'h0) // [RQ11]
        else $error("sign-of-life bits set");

    // New error raises the acknowledge request
    a_ack_set: assert property (errArrives |=> s_q.ackReq) // [RQ2]
        else $error("error did not raise ack-required");

    // Status bit follows the request flag one enabled edge later
    a_ack_status: assert property ( // [RQ2]
        clkEn |=> sensorStatusWord[SSW_ACKREQ] == $past(s_q.ackReq))
        else $error("ack-required status bit wrong");

    // Controller acknowledge clears the request
    a_ack_clear: assert property (ackSeen |=> !s_q.ackReq) // [RQ2]
        else $error("ack did not clear ack-required");

    // Error bit and error code stand while the error lasts
    a_err_hold: assert property (clkEn && s_q.errStable |=> // [RQ3]
        sensorStatusWord[SSW_ERROR] && secondPositionWord == $past(s_q.errCode))
        else $error("error not reflected in status and word two");

    // Fault bit tracks the filtered sensor error
    a_fault_bit: assert property ( // [RQ8]
        clkEn |=> encStatusWord[ESW_FAULT] == $past(s_q.errStable))
        else $error("fault bit does not follow error");

    // Completion flag on a request edge
    a_preset_done: assert property (presetEdge |=> s_q.presetDone) // [RQ4]
        else $error("preset completion not flagged");

    // Dropped request rearms the completion flag
    a_done_rearm: assert property (presetDropped |=> !s_q.presetDone) // [RQ4]
        else $error("preset completion not rearmed");

    // Absolute flag never together with the error bit
    a_abs_flag: assert property ( // [RQ5]
        sensorStatusWord[SSW_ABSVAL] |-> !sensorStatusWord[SSW_ERROR])
        else $error("absolute flag set during error");

    // Word two is zero when neither position nor error is due
    a_word_two: assert property (clkEn && !s_q.errStable && !s_q.snsCtrl[SCW_ABSREQ] |=> // [RQ5]
        secondPositionWord == 32'h0000_0000 && !sensorStatusWord[SSW_ABSVAL])
        else $error("word two not zero without request");

    // Parked while initialising
    a_park_init: assert property (clkEn && !s_q.initDone |=> sensorStatusWord[SSW_PARKED]) // [RQ6]
        else $error("parked bit missing during init");

    // Parked on controller request
    a_park_req: assert property ( // [RQ6]
        clkEn && s_q.snsCtrl[SCW_PARK] |=> sensorStatusWord[SSW_PARKED])
        else $error("parked bit missing on request");

    // Control request bit follows its register
    a_ctrl_req: assert property ( // [RQ10]
        clkEn |=> encStatusWord[ESW_CTRLREQ] == $past(s_q.ctrlReq))
        else $error("control request bit wrong");

    // Non-zero shift leaves a zero least significant bit
    a_shift_fill: assert property ( // [RQ12]
        clkEn && s_q.shift1 != 5'h00 |=> !firstPositionWord[0])
        else $error("shifted position not zero filled");

    // Wide word upper half is always zero
    a_wide_upper: assert property (widePositionWord[63:32] == 32'h0000_0000) // [RQ14]
        else $error("wide position upper half not zero");

    // Wide word lower half is the right-aligned position
    a_wide_low: assert property ( // [RQ14]
        clkEn |=> widePositionWord[31:0] == $past(posAbs))
        else $error("wide position not right aligned");

    // Long velocity is the raw value, short is its low half
    a_vel_long: assert property (clkEn |=> velocityLong == $past(rawVelocity)) // [RQ17]
        else $error("long velocity wrong");
    a_vel_short: assert property (velocityShort == velocityLong[15:0]) // [RQ17]
        else $error("short velocity not right aligned");

    // Frame without handshake leaves the stored control word alone
    a_frame_drop: assert property ( // [RQ24]
        clkEn && rxValid && !accept |=> $stable(s_q.snsCtrl))
        else $error("unhandshaked frame accepted");

    // Outgoing status words lead the frame
    a_frame_order: assert property (clkEn |=> // [RQ19]
        txFrame[95:80] == $past(encStatusWord) && txFrame[79:64] == $past(sensorStatusWord))
        else $error("outgoing frame order wrong");

    // Position words close the frame
    a_frame_tail: assert property (clkEn |=> // [RQ19]
        txFrame[63:32] == $past(firstPositionWord) && txFrame[31:0] == $past(secondPositionWord))
        else $error("outgoing frame positions wrong");

    // Zero wait states on the register bus
    a_apb_answer: assert property (clkEn && apbSetup |=> pready)
        else $error("APB answer late");

    // Low enable freezes every state bit
    a_enable_freeze: assert property (!clkEn |=> $stable(s_q))
        else $error("state changed while enable low");

endmodule : ecs_status_words
`default_nettype wire

// [tb/ecs_ctrl_model.sv]
// Behavioural cyclic controller that hands frames to the device
`timescale 1ns/10ps
`default_nettype none
module ecs_ctrl_model (
    input wire logic sys_clk,
    input wire logic sendReq,
    input wire logic [15:0] encCtrl,
    input wire logic [15:0] snsCtrl,
    output logic rxValid,
    output logic [31:0] rxFrame
);
    initial begin
        rxValid = 1'b0;
        rxFrame = 32'h0;
    end

    // One frame per request; the lines do not hold a stale frame between pulses
    always @(posedge sys_clk) begin
        rxValid <= sendReq;
        if (sendReq) begin
            rxFrame <= {encCtrl, snsCtrl};
        end else begin
            rxFrame <= ~rxFrame;
        end
    end
endmodule : ecs_ctrl_model
`default_nettype wire

// [tb/ecs_status_words_bench.sv]
// Self-checking bench for the encoder cyclic status words block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin samplesChecked++; if ((g) !== (e)) begin \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); badCount++; end end
module ecs_status_words_bench
    import ecs_pkg::*;
;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic clkEn = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic sensorErrPin = 1'b0;
    logic [31:0] rawPosition = 32'h1234;
    logic [31:0] rawVelocity = 32'h8765_4321;
    logic sendReq = 1'b0;
    logic [15:0] encCtrl = 16'h0;
    logic [15:0] snsCtrl = 16'h0;
    logic [31:0] prdata, rxFrame, pos1, pos2, velL, rdat;
    logic pready, pslverr, rxValid, rerr;
    logic [15:0] esw, ssw, velS;
    logic [63:0] posW;
    logic [95:0] txFrame;
    int badCount = 0;
    int samplesChecked = 0;
    int cycleCount = 0;

    ecs_status_words i_dut (.sys_clk(sys_clk), .srst(srst), .clkEn(clkEn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxValid(rxValid),
        .rxFrame(rxFrame), .sensorErrPin(sensorErrPin), .rawPosition(rawPosition),
        .rawVelocity(rawVelocity), .encStatusWord(esw), .sensorStatusWord(ssw),
        .firstPositionWord(pos1), .secondPositionWord(pos2), .widePositionWord(posW),
        .velocityShort(velS), .velocityLong(velL), .txFrame(txFrame));

    ecs_ctrl_model i_ctrl (.sys_clk(sys_clk), .sendReq(sendReq), .encCtrl(encCtrl),
        .snsCtrl(snsCtrl), .rxValid(rxValid), .rxFrame(rxFrame));

    // 10 MHz clock
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic finishTest;
        if (badCount == 0 && samplesChecked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finishTest

    // Hang guard, far above the hundred-odd cycles the run needs
    always @(posedge sys_clk) begin
        cycleCount++;
        if (cycleCount == 3000) begin
            badCount++;
            finishTest();
        end
    end

    // APB transfer; waits on pready instead of assuming a latency
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // One frame, then time for status and transmit frame to settle
    task automatic send(input logic [15:0] e, input logic [15:0] s);
        @(posedge sys_clk);
        sendReq <= 1'b1;
        encCtrl <= e;
        snsCtrl <= s;
        @(posedge sys_clk);
        sendReq <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask : send

    task automatic testRegs;
        apb(1'b1, REG_SHIFT, 32'h0402);
        apb(1'b1, REG_CTRL, 32'h6);
        apb(1'b0, REG_CTRL, 32'h0);
        `CHK("ctrl readback", 32'h6, rdat)
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped err", 1'b1, rerr)
        `CHK("unmapped data", 32'h0, rdat)
    endtask : testRegs

    task automatic testFormat;
        send(16'h0400, 16'h2000);
        `CHK("sensor status", 16'h2000, ssw)
        `CHK("encoder status", 16'h0200, esw)
        `CHK("first word", 32'h48d0, pos1)
        `CHK("second word", 32'h12340, pos2)
        `CHK("wide word", 64'h1234, posW)
        `CHK("velocity short", 16'h4321, velS)
        `CHK("velocity long", 32'h8765_4321, velL)
        `CHK("tx frame", {16'h0200, 16'h2000, 32'h48d0, 32'h12340}, txFrame)
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK("status read", 32'h0200_2000, rdat)
        apb(1'b0, REG_POS, 32'h0);
        `CHK("position read", 32'h48d0, rdat)
    endtask : testFormat

    // Frame without the valid-data handshake must be dropped
    task automatic testPark;
        send(16'h0000, 16'h6000);
        `CHK("park unhandshaked", 16'h2000, ssw)
        send(16'h0400, 16'h6000);
        `CHK("parked", 16'h6000, ssw)
        send(16'h0400, 16'h0000);
        `CHK("word two invalid flags", 16'h0, ssw & 16'ha000)
        `CHK("word two zero", 32'h0, pos2)
        send(16'h0400, 16'h2000);
        // Enable low: the frame is lost and status holds
        clkEn <= 1'b0;
        send(16'h0400, 16'h6000);
        `CHK("frozen status", 16'h2000, ssw)
        clkEn <= 1'b1;
    endtask : testPark

    // Preset then offset-add; request held until done is seen
    task automatic testPreset;
        apb(1'b1, REG_PRESET, 32'h64);
        send(16'h0400, 16'h3000);
        `CHK("preset done", 16'h3000, ssw)
        `CHK("preset pos", 32'h190, pos1)
        send(16'h0400, 16'h2800);
        `CHK("done cleared", 16'h2000, ssw)
        send(16'h0400, 16'h3800);
        `CHK("offset done", 16'h3000, ssw)
        `CHK("offset pos", 64'hc8, posW)
        send(16'h0400, 16'h2000);
    endtask : testPreset

    task automatic testError;
        apb(1'b1, REG_ERRCODE, 32'h55);
        sensorErrPin <= 1'b1;
        repeat (8) @(posedge sys_clk);
        `CHK("error status", 16'h8800, ssw)
        `CHK("fault bit", 16'h0208, esw)
        `CHK("values flagged invalid", 1'b1, esw[ESW_FAULT])
        `CHK("error code", 32'h55, pos2)
        send(16'h0400, 16'ha000);
        `CHK("acked error", 16'h8000, ssw)
        sensorErrPin <= 1'b0;
        send(16'h0400, 16'h2000);
        `CHK("error gone", 16'h2000, ssw)
        `CHK("fault gone", 16'h0200, esw)
    endtask : testError

    // Reset, then scenarios in turn
    initial begin
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK("parked at init", 16'h4000, ssw)
        `CHK("enc status reset", 16'h0, esw)
        testRegs();
        testFormat();
        testPark();
        testPreset();
        testError();
        finishTest();
    end
endmodule : ecs_status_words_bench
`default_nettype wire
